/* File: fpec_ctrl.sv */
// flash program/erase sequencer with control register and event interrupt
//
// Summary of operation
// - setting start launches a self-timed operation; hardware clears start on completion
// - software may set start but writing zero to it does nothing
// - operations run only while the arm bit is one
// - erase with code 1101 erases general segment; other erase codes do nothing
// - program with code 0011 programs one word; other program codes do nothing
// - control bits return to zero only on power-on reset
// - each location is 24 bits: lower word even, upper word odd, top byte absent
// - addresses align to lower word and step by two per location
// - addresses below 0x000200 hold fixed vectors, reset jump and start-of-code
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fpec_ctrl #(
    parameter int PROG_CYC  = fpec_pkg::PROG_CYCLES,   // program duration in cycles
    parameter int ERASE_CYC = fpec_pkg::ERASE_CYCLES,  // erase duration in cycles
    parameter int CNT_W     = 16                       // timer width
) (
    input  wire logic        clk,          // system clock, 100 MHz
    input  wire logic        rst_b,        // power-on reset, active low
    input  wire logic        sys_rst_b,    // other reset sources, active low, async pin
    input  wire logic [3:0]  reg_addr,     // register index
    input  wire logic [15:0] reg_wdata,    // write data
    input  wire logic        reg_wr,       // write strobe
    input  wire logic        reg_rd,       // read strobe
    output var  logic [15:0] reg_rdata,    // read data, cycle after strobe
    output var  logic        irq,          // level interrupt
    output var  logic        flash_prog,   // program pulse to array macro
    output var  logic        flash_erase,  // general segment erase to array macro
    output var  logic        flash_busy,   // operation in progress
    output var  logic [23:0] flash_addr,   // aligned target address
    output var  logic [23:0] flash_wdata   // 24-bit word to program
);
    // refuse durations that the timer width cannot count
    if (PROG_CYC < 1 || PROG_CYC >= (1 << CNT_W)) begin : g_bad_prog
        $error("fpec_ctrl: bad PROG_CYC");
    end
    if (ERASE_CYC < 1 || ERASE_CYC >= (1 << CNT_W)) begin : g_bad_erase
        $error("fpec_ctrl: bad ERASE_CYC");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic                      start_q, start_d;
    logic                      arm_q, arm_d;
    logic                      fault_q, fault_d;
    logic                      erase_sel_q, erase_sel_d;
    logic [3:0]                op_q, op_d;
    logic [23:0]               addr_q, addr_d;
    logic [15:0]               data_lo_q, data_lo_d;
    logic [7:0]                data_hi_q, data_hi_d;
    logic [fpec_pkg::EV_W-1:0] stat_q, stat_d;
    logic [fpec_pkg::EV_W-1:0] en_q, en_d;
    fpec_pkg::fpec_state_e     st_q, st_d;
    logic                      prog_q, prog_d;
    logic                      erase_q, erase_d;
    logic [15:0]               rdata_q, rdata_d;
    logic                      irq_q, irq_d;
    logic                      srst_m_q, srst_q;

    logic             wr_ctrl;
    logic             op_valid;
    logic             launch;
    logic             t_load;
    logic [CNT_W-1:0] t_len;
    logic             t_exp;
    logic             abort;
    logic [fpec_pkg::EV_W-1:0] ev;
    logic [15:0]      ctrl_view;

    // ---------------------------------------------------------------
    // non-power-on reset synchroniser; used only to abort an operation
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            srst_m_q    <= 1'b1;
            srst_q      <= 1'b1;
        end else begin
            srst_m_q    <= sys_rst_b;
            srst_q      <= srst_m_q;
        end
    end

    // ---------------------------------------------------------------
    // decode of a start request
    // ---------------------------------------------------------------
    always_comb begin
        wr_ctrl = reg_wr && (reg_addr == fpec_pkg::OFS_CTRL);
        // erase general segment or program one word; all else is no-op
        op_valid = reg_wdata[fpec_pkg::CTRL_ERASE]
                 ? (reg_wdata[3:0] == fpec_pkg::OP_ERASE_GENERAL)
                 : (reg_wdata[3:0] == fpec_pkg::OP_PROGRAM_WORD);
        // armed, valid and idle, else refused
        launch = wr_ctrl && reg_wdata[fpec_pkg::CTRL_START] && !start_q
               && reg_wdata[fpec_pkg::CTRL_ARM] && op_valid;
        // other resets only cut a running op, never clear control bits
        abort  = (st_q == fpec_pkg::ST_BUSY) && !srst_q;
        t_load = launch;
        t_len  = reg_wdata[fpec_pkg::CTRL_ERASE] ? CNT_W'(ERASE_CYC) : CNT_W'(PROG_CYC);
    end

    fpec_timer #(
        .CNT_W   (CNT_W)
    ) u_timer (
        .clk     (clk),
        .rst_b   (rst_b),
        .load    (t_load),
        .length  (t_len),
        .expired (t_exp)
    );

    // ---------------------------------------------------------------
    // sequencer and control register next values
    // ---------------------------------------------------------------
    always_comb begin
        start_d     = start_q;
        arm_d       = arm_q;
        fault_d     = fault_q;
        erase_sel_d = erase_sel_q;
        op_d        = op_q;
        st_d        = st_q;
        prog_d      = 1'b0;
        erase_d     = 1'b0;
        ev          = '0;
        if (wr_ctrl && !start_q) begin
            arm_d       = reg_wdata[fpec_pkg::CTRL_ARM];
            erase_sel_d = reg_wdata[fpec_pkg::CTRL_ERASE];
            op_d        = reg_wdata[fpec_pkg::CTRL_OP_LSB +: fpec_pkg::CTRL_OP_W];
            if (reg_wdata[fpec_pkg::CTRL_START]) begin
                if (launch) begin
                    start_d = 1'b1;   // software can only set it
                    fault_d = 1'b0;
                end else begin
                    fault_d = 1'b1;   // refused attempt
                    ev[fpec_pkg::EV_FAULT] = 1'b1;
                end
            end else begin
                fault_d = reg_wdata[fpec_pkg::CTRL_FAULT] & fault_q;
            end
        end else if (wr_ctrl && start_q) begin
            arm_d = reg_wdata[fpec_pkg::CTRL_ARM];  // start ignores written zero
        end
        case (st_q)
            fpec_pkg::ST_IDLE: begin
                if (launch) begin
                    st_d    = fpec_pkg::ST_BUSY;
                    prog_d  = !reg_wdata[fpec_pkg::CTRL_ERASE];
                    erase_d = reg_wdata[fpec_pkg::CTRL_ERASE];
                end
            end
            fpec_pkg::ST_BUSY: begin
                prog_d  = !erase_sel_q;
                erase_d = erase_sel_q;
                if (abort || !arm_d) begin
                    st_d    = fpec_pkg::ST_IDLE;   // terminated
                    start_d = 1'b0;
                    fault_d = 1'b1;
                    prog_d  = 1'b0;
                    erase_d = 1'b0;
                    ev[fpec_pkg::EV_FAULT] = 1'b1;
                end else if (t_exp) begin
                    st_d    = fpec_pkg::ST_DONE;
                    prog_d  = 1'b0;
                    erase_d = 1'b0;
                end
            end
            fpec_pkg::ST_DONE: begin
                st_d    = fpec_pkg::ST_IDLE;
                start_d = 1'b0;           // hardware completion clears start
                fault_d = 1'b0;           // normal completion
                ev[fpec_pkg::EV_DONE] = 1'b1;
            end
            default: st_d = fpec_pkg::ST_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // address, data and interrupt registers
    // ---------------------------------------------------------------
    always_comb begin
        addr_d    = addr_q;
        data_lo_d = data_lo_q;
        data_hi_d = data_hi_q;
        en_d      = en_q;
        stat_d    = stat_q;
        if (reg_wr && !start_q) begin
            case (reg_addr)
                fpec_pkg::OFS_ADDR:    addr_d[15:0]  = {reg_wdata[15:1], 1'b0};
                fpec_pkg::OFS_ADDR_HI: addr_d[23:16] = reg_wdata[7:0];
                fpec_pkg::OFS_DATA_LO: data_lo_d     = reg_wdata;
                fpec_pkg::OFS_DATA_HI: data_hi_d     = reg_wdata[7:0];
                default: ;
            endcase
        end
        if (reg_wr && reg_addr == fpec_pkg::OFS_IRQ_EN) begin
            en_d = reg_wdata[fpec_pkg::EV_W-1:0];
        end
        if (reg_wr && reg_addr == fpec_pkg::OFS_IRQ_CLR) begin
            stat_d = stat_q & ~reg_wdata[fpec_pkg::EV_W-1:0];
        end
        stat_d = stat_d | ev;             // set wins over clear
        irq_d  = |(stat_d & en_d);
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always_comb begin
        ctrl_view = fpec_pkg::CTRL_RESET;
        ctrl_view[fpec_pkg::CTRL_START] = start_q;
        ctrl_view[fpec_pkg::CTRL_ARM]   = arm_q;
        ctrl_view[fpec_pkg::CTRL_FAULT] = fault_q;
        ctrl_view[fpec_pkg::CTRL_ERASE] = erase_sel_q;
        ctrl_view[fpec_pkg::CTRL_OP_LSB +: fpec_pkg::CTRL_OP_W] = op_q;
        rdata_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                fpec_pkg::OFS_CTRL:    rdata_d = ctrl_view;
                fpec_pkg::OFS_STATUS:  rdata_d = {14'h0000, stat_q};
                fpec_pkg::OFS_IRQ_EN:  rdata_d = {14'h0000, en_q};
                fpec_pkg::OFS_ADDR:    rdata_d = addr_q[15:0];
                fpec_pkg::OFS_ADDR_HI: rdata_d = {8'h00, addr_q[23:16]};
                fpec_pkg::OFS_DATA_LO: rdata_d = data_lo_q;
                fpec_pkg::OFS_DATA_HI: rdata_d = {8'h00, data_hi_q};  // top byte absent
                default:               rdata_d = 16'h0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registers; only power-on reset clears control bits
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_q     <= 1'b0;
            arm_q       <= 1'b0;
            fault_q     <= 1'b0;
            erase_sel_q <= 1'b0;
            op_q        <= 4'h0;
            st_q        <= fpec_pkg::ST_IDLE;
            prog_q      <= 1'b0;
            erase_q     <= 1'b0;
            addr_q      <= fpec_pkg::START_OF_CODE;  // start-of-code vector
            data_lo_q   <= 16'h0000;
            data_hi_q   <= 8'h00;
            stat_q      <= '0;
            en_q        <= '0;
            rdata_q     <= 16'h0000;
            irq_q       <= 1'b0;
        end else begin
            start_q     <= start_d;
            arm_q       <= arm_d;
            fault_q     <= fault_d;
            erase_sel_q <= erase_sel_d;
            op_q        <= op_d;
            st_q        <= st_d;
            prog_q      <= prog_d;
            erase_q     <= erase_d;
            addr_q      <= addr_d;
            data_lo_q   <= data_lo_d;
            data_hi_q   <= data_hi_d;
            stat_q      <= stat_d;
            en_q        <= en_d;
            rdata_q     <= rdata_d;
            irq_q       <= irq_d;
        end
    end

    // outputs straight from registers
    assign reg_rdata   = rdata_q;
    assign irq         = irq_q;
    assign flash_prog  = prog_q;
    assign flash_erase = erase_q;
    assign flash_busy  = start_q;
    assign flash_addr  = addr_q;
    assign flash_wdata = {data_hi_q, data_lo_q};
endmodule : fpec_ctrl
`default_nettype wire

/* File: fpec_pkg.sv */
// package: register layout, codes and timing for the flash program/erase control
package fpec_pkg;
    // ---------------------------------------------------------------
    // register offsets (word index on the plain port)
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL     = 4'h0;  // flash_operation_control
    localparam logic [3:0] OFS_STATUS   = 4'h1;  // sticky event status, read only
    localparam logic [3:0] OFS_IRQ_EN   = 4'h2;  // event enable
    localparam logic [3:0] OFS_IRQ_CLR  = 4'h3;  // event clear, write only
    localparam logic [3:0] OFS_ADDR     = 4'h4;  // target program address, low 16 bits
    localparam logic [3:0] OFS_ADDR_HI  = 4'h5;  // target program address, bits 23:16
    localparam logic [3:0] OFS_DATA_LO  = 4'h6;  // lower word of program data
    localparam logic [3:0] OFS_DATA_HI  = 4'h7;  // upper word (low byte used)

    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int CTRL_START   = 15;
    localparam int CTRL_ARM     = 14;
    localparam int CTRL_FAULT   = 13;
    localparam int CTRL_ERASE   = 6;
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_OP_W    = 4;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // ---------------------------------------------------------------
    // operation codes
    // ---------------------------------------------------------------
    localparam logic [3:0] OP_ERASE_GENERAL = 4'hd;
    localparam logic [3:0] OP_PROGRAM_WORD  = 4'h3;

    // ---------------------------------------------------------------
    // status / interrupt event bits
    // ---------------------------------------------------------------
    localparam int EV_DONE   = 0;
    localparam int EV_FAULT  = 1;
    localparam int EV_W      = 2;

    // ---------------------------------------------------------------
    // memory map
    // ---------------------------------------------------------------
    localparam int ADDR_W                 = 24;
    localparam logic [23:0] VEC_END       = 24'h000200;
    localparam logic [23:0] RESET_JUMP    = 24'h000000;
    localparam logic [23:0] START_OF_CODE = 24'h000002;
    localparam int PM_WORD_W              = 24;
    localparam logic [23:0] ADDR_STEP     = 24'h000002;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ           = 100;
    localparam int PROG_TIME_US      = 20;
    localparam int ERASE_TIME_US     = 20;
    localparam int PROG_CYCLES       = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES      = ERASE_TIME_US * CLK_MHZ;

    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BUSY  = 2'b01,
        ST_DONE  = 2'b10
    } fpec_state_e;
endpackage : fpec_pkg

/* File: fpec_timer.sv */
// self-timed operation counter
`timescale 1ns/100ps
`default_nettype none
module fpec_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk,      // system clock
    input  wire logic             rst_b,    // power-on reset, active low
    input  wire logic             load,     // start a new timed interval
    input  wire logic [CNT_W-1:0] length,   // interval length in cycles
    output var  logic             expired   // one-cycle pulse at end of interval
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             run_q;
    logic             run_d;
    logic             exp_q;
    logic             exp_d;

    // refuse a counter too narrow to count down
    if (CNT_W < 2) begin : g_bad_width
        $error("fpec_timer: CNT_W too small");
    end

    // ---------------------------------------------------------------
    // countdown
    // ---------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (load) begin
            cnt_d = length;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q <= CNT_W'(1)) begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end else begin
                cnt_d = cnt_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;
endmodule : fpec_timer
`default_nettype wire

/* File: fpec_ctrl_monitor.sv */
// checker: port-level properties of the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module fpec_ctrl_chk #(
    parameter int PROG_CYC  = 5, // program cycles
    parameter int ERASE_CYC = 5  // erase cycles
) (
    input wire logic        clk,         // clock
    input wire logic        rst_b,       // power-on reset
    input wire logic        sys_rst_b,   // other resets
    input wire logic [3:0]  reg_addr,    // index
    input wire logic [15:0] reg_wdata,   // write data
    input wire logic        reg_wr,      // write strobe
    input wire logic        reg_rd,      // read strobe
    input wire logic [15:0] reg_rdata,   // read data
    input wire logic        irq,         // interrupt
    input wire logic        flash_prog,  // program level
    input wire logic        flash_erase, // erase level
    input wire logic        flash_busy,  // start bit
    input wire logic [23:0] flash_addr,  // target address
    input wire logic [23:0] flash_wdata  // target word
);
    localparam logic [31:0] BUSY_MAX = 32'(((PROG_CYC > ERASE_CYC) ? PROG_CYC : ERASE_CYC) + 4);
    logic        ctl_wr;
    logic        arm_go;
    logic [31:0] busy_cnt_d;
    logic [31:0] busy_cnt_q;

    // ---------------------------------------------------------------
    // helper decode and busy length counter
    // ---------------------------------------------------------------
    assign ctl_wr = reg_wr && (reg_addr == fpec_pkg::OFS_CTRL);
    assign arm_go = ctl_wr && reg_wdata[15] && reg_wdata[14] && !flash_busy;
    always_comb begin
        busy_cnt_d = flash_busy ? busy_cnt_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    prog_launch_a: assert property (
        arm_go && !reg_wdata[6] && reg_wdata[3:0] == fpec_pkg::OP_PROGRAM_WORD
        |=> flash_busy && flash_prog && !flash_erase) else $error("program not launched");
    erase_launch_a: assert property (
        arm_go && reg_wdata[6] && reg_wdata[3:0] == fpec_pkg::OP_ERASE_GENERAL
        |=> flash_busy && flash_erase && !flash_prog) else $error("erase not launched");
    bad_erase_a: assert property (
        arm_go && reg_wdata[6] && reg_wdata[3:0] != fpec_pkg::OP_ERASE_GENERAL
        |=> !flash_busy && !flash_erase) else $error("bad erase code ran");
    bad_prog_a: assert property (
        arm_go && !reg_wdata[6] && reg_wdata[3:0] != fpec_pkg::OP_PROGRAM_WORD
        |=> !flash_busy && !flash_prog) else $error("bad program code ran");
    unarmed_start_a: assert property (
        ctl_wr && reg_wdata[15] && !reg_wdata[14] && !flash_busy
        |=> !flash_busy && !flash_prog && !flash_erase) else $error("unarmed start ran");
    arm_drop_a: assert property (
        flash_busy && ctl_wr && !reg_wdata[14] |-> ##[1:2] !flash_busy)
        else $error("disarm did not stop op");
    start_hold_a: assert property (
        flash_prog && ctl_wr && reg_wdata[14] && !reg_wdata[15] |=> flash_busy)
        else $error("start cleared by write");
    done_clear_a: assert property (
        flash_busy && ($fell(flash_prog) || $fell(flash_erase)) |=> !flash_busy)
        else $error("start not cleared");
    op_in_busy_a: assert property (
        (flash_prog || flash_erase) |-> flash_busy && !(flash_prog && flash_erase))
        else $error("op level outside busy");
    busy_bound_a: assert property (
        busy_cnt_q <= BUSY_MAX) else $error("operation never completes");
    addr_align_a: assert property (
        flash_addr[0] == 1'b0) else $error("target address odd");
endmodule : fpec_ctrl_chk

bind fpec_ctrl fpec_ctrl_chk #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) chk_u (
    .clk(clk), .rst_b(rst_b), .sys_rst_b(sys_rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_busy(flash_busy), .flash_addr(flash_addr), .flash_wdata(flash_wdata));
`default_nettype wire

/* File: tb.sv */
// testbench: register-level tests of the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        sys_rst_b = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        irq, flash_prog, flash_erase, flash_busy;
    logic [23:0] flash_addr, flash_wdata;
    int          failures = 0;
    int          cmp_count = 0;
    logic [4:0]  bad_q [8] = '{5'h1f, 5'h1c, 5'h13, 5'h10, 5'h0f, 5'h0d, 5'h02, 5'h00};

    // ---------------------------------------------------------------
    // clock and design
    // ---------------------------------------------------------------
    always #5 clk = ~clk;
    fpec_ctrl #(.PROG_CYC(5), .ERASE_CYC(5)) dut_u (
        .clk(clk), .rst_b(rst_b), .sys_rst_b(sys_rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .flash_prog(flash_prog), .flash_erase(flash_erase),
        .flash_busy(flash_busy), .flash_addr(flash_addr), .flash_wdata(flash_wdata));

    // ---------------------------------------------------------------
    // access and compare tasks
    // ---------------------------------------------------------------
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rchk
    // op outputs as {busy, erase, prog}, sampled just after the taking edge
    task automatic ops(input logic [2:0] exp);
        #1;
        chk({21'h0, flash_busy, flash_erase, flash_prog}, {21'h0, exp});
    endtask : ops
    task automatic wait_idle();
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            #1;
            if (flash_busy === 1'b0) return;
        end
        failures++;
        stop_test();
    endtask : wait_idle

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk(flash_addr, fpec_pkg::START_OF_CODE);
        rchk(fpec_pkg::OFS_CTRL, 16'h0000);
        // program one word with the done event enabled
        wr(fpec_pkg::OFS_IRQ_EN, 16'h0001);
        wr(fpec_pkg::OFS_ADDR_HI, 16'h0001);
        wr(fpec_pkg::OFS_ADDR, 16'h0235);
        wr(fpec_pkg::OFS_DATA_LO, 16'hbeef);
        wr(fpec_pkg::OFS_DATA_HI, 16'ha5c3);
        wr(fpec_pkg::OFS_CTRL, 16'hc003);
        ops(3'b101);
        chk(flash_addr, 24'h010234);
        chk(flash_wdata, 24'hc3beef);
        wr(fpec_pkg::OFS_CTRL, 16'h4003);
        ops(3'b101);
        wait_idle();
        rchk(fpec_pkg::OFS_CTRL, 16'h4003);
        rchk(fpec_pkg::OFS_STATUS, 16'h0001);
        chk({23'h0, irq}, 24'h000001);
        wr(fpec_pkg::OFS_IRQ_CLR, 16'h0001);
        wr(fpec_pkg::OFS_STATUS, 16'hffff);
        rchk(fpec_pkg::OFS_STATUS, 16'h0000);
        chk({23'h0, irq}, 24'h000000);
        rchk(fpec_pkg::OFS_IRQ_CLR, 16'h0000);
        rchk(4'h9, 16'h0000);
        // erase with the done event masked
        wr(fpec_pkg::OFS_IRQ_EN, 16'h0002);
        wr(fpec_pkg::OFS_CTRL, 16'hc04d);
        ops(3'b110);
        wait_idle();
        rchk(fpec_pkg::OFS_CTRL, 16'h404d);
        rchk(fpec_pkg::OFS_STATUS, 16'h0001);
        chk({23'h0, irq}, 24'h000000);
        wr(fpec_pkg::OFS_IRQ_CLR, 16'h0001);
        // four no-operation codes for each of the two selections
        for (int i = 0; i < 8; i++) begin
            wr(fpec_pkg::OFS_CTRL, {8'hc0, 1'b0, bad_q[i][4], 2'b00, bad_q[i][3:0]});
            ops(3'b000);
            rchk(fpec_pkg::OFS_CTRL, {8'h60, 1'b0, bad_q[i][4], 2'b00, bad_q[i][3:0]});
        end
        rchk(fpec_pkg::OFS_STATUS, 16'h0002);
        chk({23'h0, irq}, 24'h000001);
        wr(fpec_pkg::OFS_IRQ_CLR, 16'h0002);
        // start while disarmed, then a clean run clears the fault
        wr(fpec_pkg::OFS_CTRL, 16'h8003);
        ops(3'b000);
        rchk(fpec_pkg::OFS_CTRL, 16'h2003);
        wr(fpec_pkg::OFS_CTRL, 16'hc003);
        wait_idle();
        rchk(fpec_pkg::OFS_CTRL, 16'h4003);
        // disarm in mid-operation terminates it
        wr(fpec_pkg::OFS_CTRL, 16'hc003);
        wr(fpec_pkg::OFS_CTRL, 16'h0003);
        rchk(fpec_pkg::OFS_CTRL, 16'h2003);
        ops(3'b000);
        // other reset sources keep control bits
        wr(fpec_pkg::OFS_CTRL, 16'h404d);
        sys_rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        sys_rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(fpec_pkg::OFS_CTRL, 16'h404d);
        // other reset during an erase terminates it and keeps the settings
        wr(fpec_pkg::OFS_CTRL, 16'hc04d);
        sys_rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        sys_rst_b <= 1'b1;
        ops(3'b000);
        rchk(fpec_pkg::OFS_CTRL, 16'h604d);
        // second power-on reset clears them
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rchk(fpec_pkg::OFS_CTRL, 16'h0000);
        chk(flash_addr, fpec_pkg::START_OF_CODE);
        stop_test();
    end
endmodule : tb
`default_nettype wire
